/* File: common/sccsf_pkg.sv */
// constants and carrier types of the serial channel control and status block
package sccsf_pkg;
    // ======================================================
    // register indices on the plain register port
    localparam logic [2:0] SCCSF_OFS_MODE   = 3'h0;
    localparam logic [2:0] SCCSF_OFS_CTRL   = 3'h1;
    localparam logic [2:0] SCCSF_OFS_STAT   = 3'h2;
    localparam logic [2:0] SCCSF_OFS_CARD   = 3'h3;
    localparam logic [2:0] SCCSF_OFS_TXHOLD = 3'h4;
    localparam logic [2:0] SCCSF_OFS_RXHOLD = 3'h5;
    // ======================================================
    // control register fields
    localparam int SCCSF_CTL_TIE  = 7;
    localparam int SCCSF_CTL_RIE  = 6;
    localparam int SCCSF_CTL_TE   = 5;
    localparam int SCCSF_CTL_RE   = 4;
    localparam int SCCSF_CTL_MULTIPROC_SKIP_ENABLE = 3;
    localparam int SCCSF_CTL_TX_END_IRQ_ENABLE = 2;
    localparam int SCCSF_CTL_CKHI = 1;
    localparam int SCCSF_CTL_CKLO = 0;
    // status register fields
    localparam int SCCSF_ST_TX_DATA_EMPTY_FLAG = 7;
    localparam int SCCSF_ST_RX_DATA_FULL_FLAG = 6;
    localparam int SCCSF_ST_OVERRUN_FLAG = 5;
    localparam int SCCSF_ST_FER  = 4;
    localparam int SCCSF_ST_PER  = 3;
    localparam int SCCSF_ST_TX_END_FLAG = 2;
    localparam int SCCSF_ST_MPB  = 1;
    localparam int SCCSF_ST_MPBT = 0;
    // mode register fields (bit 7 is the alt timing bit in card mode)
    localparam int SCCSF_MD_SYNC = 7;
    localparam int SCCSF_MD_GM   = 7;
    localparam int SCCSF_MD_MP   = 2;
    // card mode register fields
    localparam int SCCSF_CM_CARD_MODE_SELECT = 0;
    // ======================================================
    // reset values
    localparam logic [7:0] SCCSF_RST_MODE = 8'h00;
    localparam logic [7:0] SCCSF_RST_CTRL = 8'h00;
    localparam logic [7:0] SCCSF_RST_CARD = 8'hF2;
    localparam logic [7:0] SCCSF_CARD_RSV = 8'h72;
    localparam logic [7:0] SCCSF_RST_DATA = 8'h00;
    // ======================================================
    // one received character as handed over by the receive shifter
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       rx_multiproc_bit;
        logic       par_err;
        logic       stop_err;
    } sccsf_rx_evt_t;

    // interrupt request lines
    typedef struct packed {
        logic tx_empty_request;
        logic rx_full_request;
        logic rx_error_request;
        logic tx_end_request;
    } sccsf_req_t;

    // clock pin roles
    typedef enum logic [3:0] {
        SCCSF_CK_PORT = 4'b0001,
        SCCSF_CK_OUT  = 4'b0010,
        SCCSF_CK_IN   = 4'b0100,
        SCCSF_CK_FIX  = 4'b1000
    } sccsf_ck_t;
endpackage

/* File: tb/sccsf_line_model.sv */
// far-side model: line transceiver, shifter strobes and link clock
`timescale 1ns/1ps
module sccsf_line_model (
    input  wire logic                clk_sys,
    input  wire logic                tx_go,
    output sccsf_pkg::sccsf_rx_evt_t rx_evt,
    output logic                     tx_load,
    output logic                     tx_last_bit,
    output logic                     bit_clk,
    output logic                     rxd_pin,
    output logic                     sck_pin_in
);
    int tx_delay = 3;
    initial begin
        rx_evt = '0;
        tx_load = 1'b0;
        tx_last_bit = 1'b0;
        bit_clk = 1'b0;
        rxd_pin = 1'b1;
        sck_pin_in = 1'b1;
    end
    always begin
        repeat (4) @(posedge clk_sys);
        bit_clk <= ~bit_clk;
    end
    // ========
    // shifter takes the holding register some cycles after go
    always begin
        @(posedge clk_sys);
        if (tx_go === 1'b1) begin
            repeat (tx_delay) @(posedge clk_sys);
            tx_load <= 1'b1;
            @(posedge clk_sys);
            tx_load <= 1'b0;
            repeat (8) @(posedge clk_sys);
            tx_last_bit <= 1'b1;
            @(posedge clk_sys);
            tx_last_bit <= 1'b0;
        end
    end
    // one character: start bit, link clock only inside the frame, then done
    task automatic send_char(input logic [7:0] d, input logic mp, input logic pe,
                             input logic se);
        @(posedge clk_sys);
        #7;
        rxd_pin <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            #100;
            sck_pin_in <= ~sck_pin_in;
        end
        @(posedge clk_sys);
        rx_evt <= '{1'b1, d, mp, pe, se};
        rxd_pin <= 1'b1;
        @(posedge clk_sys);
        rx_evt <= '{1'b0, ~d, ~mp, ~pe, ~se};
    endtask
endmodule

/* File: tb/sccsf_serial_ctrl_assertions.sv */
// port-level assertions of the serial channel control block
`timescale 1ns/1ps
module sccsf_serial_ctrl_assertions (
    input wire logic                     clk_sys,
    input wire logic                     rst_n,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [7:0]               reg_rdata,
    input wire sccsf_pkg::sccsf_rx_evt_t rx_evt,
    input wire logic                     tx_load,
    input wire logic                     dma_tx_write,
    input wire logic                     dma_rx_read,
    input wire logic                     sck_pin_oe,
    input wire logic                     ext_clk_edge,
    input wire logic                     rx_start,
    input wire logic                     rx_halt,
    input wire logic                     tx_go,
    input wire sccsf_pkg::sccsf_req_t    req
);
    logic [1:0] up_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ========
    // cycles since reset, so the first settling of rx_halt is not judged
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    a_rdata_one_cycle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_go_clears_empty: assert property (tx_go |-> !req.tx_empty_request)
        else $error("empty request while transmit runs");
    a_load_ends_go: assert property (tx_load |-> ##[1:2] !tx_go)
        else $error("transmit go stays after load");
    a_empty_rise_cause: assert property ($rose(req.tx_empty_request) |->
        $past(tx_load, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("empty request rose without cause");
    a_empty_fall_cause: assert property ($fell(req.tx_empty_request) |->
        $past(reg_wr) || $past(reg_wr, 2) || $past(dma_tx_write) || $past(dma_tx_write, 2))
        else $error("empty request fell without cause");
    a_full_rise_cause: assert property ($rose(req.rx_full_request) |->
        $past(rx_evt.done, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("full request rose without cause");
    a_dma_read_drops: assert property (dma_rx_read && !rx_evt.done ##1 !rx_evt.done
        |=> !req.rx_full_request)
        else $error("full request stays after dma read");
    a_halt_has_cause: assert property (up_r == 2'h3 && $changed(rx_halt) |->
        $past(reg_wr) || $past(reg_wr, 2) || $past(rx_evt.done) || $past(rx_evt.done, 2))
        else $error("receive halt changed without cause");
    a_ext_edge_input: assert property (ext_clk_edge |-> !sck_pin_oe)
        else $error("external edge while pin driven");
    a_start_not_halted: assert property (rx_start |-> !rx_halt)
        else $error("reception started while halted");
    c_error_req: cover property (req.rx_error_request);
    c_ext_edge: cover property (ext_clk_edge);
    c_tx_go: cover property ($rose(tx_go));
endmodule
bind sccsf_serial_ctrl sccsf_serial_ctrl_assertions i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_evt(rx_evt), .tx_load(tx_load),
    .dma_tx_write(dma_tx_write), .dma_rx_read(dma_rx_read), .sck_pin_oe(sck_pin_oe),
    .ext_clk_edge(ext_clk_edge), .rx_start(rx_start), .rx_halt(rx_halt),
    .tx_go(tx_go), .req(req));

/* File: tb/sccsf_serial_ctrl_test.sv */
// self-checking bench of the serial channel control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module sccsf_serial_ctrl_test;
    localparam logic [2:0] MD = sccsf_pkg::SCCSF_OFS_MODE;
    localparam logic [2:0] CT = sccsf_pkg::SCCSF_OFS_CTRL;
    localparam logic [2:0] ST = sccsf_pkg::SCCSF_OFS_STAT;
    localparam logic [2:0] CD = sccsf_pkg::SCCSF_OFS_CARD;
    localparam logic [2:0] TH = sccsf_pkg::SCCSF_OFS_TXHOLD;
    localparam logic [2:0] RH = sccsf_pkg::SCCSF_OFS_RXHOLD;
    logic                     clk_sys = 1'b0;
    logic                     rst_n = 1'b0;
    logic [2:0]               reg_addr = 3'h0;
    logic [7:0]               reg_wdata = 8'h00;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic                     dma_tx_write = 1'b0;
    logic [7:0]               dma_tx_data = 8'h00;
    logic                     dma_rx_read = 1'b0;
    logic [7:0]               reg_rdata, tx_holding, rd_v;
    logic                     tx_load, tx_last_bit, bit_clk, rxd_pin, sck_pin_in;
    logic                     sck_pin_out, sck_pin_oe, ext_clk_edge, rx_start;
    logic                     rx_halt, tx_go, tx_halt, tx_mp_bit;
    sccsf_pkg::sccsf_rx_evt_t rx_evt;
    sccsf_pkg::sccsf_req_t    req;
    int                       n_errors = 0;
    int                       checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    sccsf_serial_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_evt(rx_evt), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
        .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
        .bit_clk(bit_clk), .rxd_pin(rxd_pin), .sck_pin_in(sck_pin_in),
        .sck_pin_out(sck_pin_out), .sck_pin_oe(sck_pin_oe), .ext_clk_edge(ext_clk_edge),
        .rx_start(rx_start), .rx_halt(rx_halt), .tx_go(tx_go), .tx_halt(tx_halt),
        .tx_holding(tx_holding), .tx_mp_bit(tx_mp_bit), .req(req));
    sccsf_line_model i_line (.clk_sys(clk_sys), .tx_go(tx_go), .rx_evt(rx_evt),
        .tx_load(tx_load), .tx_last_bit(tx_last_bit), .bit_clk(bit_clk),
        .rxd_pin(rxd_pin), .sck_pin_in(sck_pin_in));
    // ========
    // register port and waiting helpers
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        `CHK(rd_v, e)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_on(input int which);
        int i;
        for (i = 0; i < 400; i++) begin
            settle(1);
            if ((which == 0 ? tx_load : tx_last_bit) === 1'b1) break;
        end
        if (i == 400) begin
            n_errors++;
            final_report();
        end
    endtask
    // ========
    // scenarios
    task automatic t_reset();
        rchk(CT, 8'h00);
        rchk(ST, 8'h84);
        rchk(CD, 8'hF2);
        rchk(3'h6, 8'h00);
        wr(ST, 8'hFF);
        rchk(ST, 8'h85);
        `CHK({tx_mp_bit, tx_halt}, 2'h3)
        wr(ST, 8'h00);
        rchk(ST, 8'h84);
    endtask
    task automatic t_transmit();
        wr(MD, 8'h00);
        wr(CT, 8'hA0);
        wr(TH, 8'h3C);
        `CHK(req, 4'h8)
        rchk(ST, 8'h84);
        i_line.tx_delay = 6;
        wr(ST, 8'h7E);
        settle(1);
        `CHK({req, tx_go, tx_halt, tx_holding}, 14'h023C)
        wait_on(0);
        settle(2);
        `CHK({req, tx_go}, 5'h10)
        wait_on(1);
        rchk(ST, 8'h84);
        wr(CT, 8'hA4);
        settle(1);
        `CHK(req, 4'h9)
        i_line.tx_delay = 1;
        @(posedge clk_sys);
        dma_tx_write <= 1'b1;
        dma_tx_data <= 8'hC3;
        @(posedge clk_sys);
        dma_tx_write <= 1'b0;
        settle(1);
        `CHK({req, tx_holding}, 12'h0C3)
        wait_on(1);
        wr(CT, 8'h00);
        settle(1);
        `CHK(req, 4'h0)
    endtask
    task automatic t_receive();
        wr(CT, 8'h50);
        i_line.send_char(8'h55, 1'b0, 1'b0, 1'b0);
        settle(1);
        `CHK(req, 4'h4)
        rchk(RH, 8'h55);
        i_line.send_char(8'hAA, 1'b0, 1'b0, 1'b0);
        rchk(ST, 8'hE4);
        rchk(RH, 8'h55);
        `CHK({rx_halt, req}, 5'h16)
        wr(ST, 8'h84);
        rchk(ST, 8'h84);
        `CHK(req, 4'h0)
        i_line.send_char(8'h33, 1'b0, 1'b0, 1'b1);
        rchk(ST, 8'h94);
        rchk(RH, 8'h33);
        wr(CT, 8'h40);
        rchk(ST, 8'h94);
        wr(ST, 8'h84);
        wr(CT, 8'h50);
        i_line.send_char(8'h0F, 1'b0, 1'b1, 1'b0);
        rchk(ST, 8'h8C);
        i_line.send_char(8'h77, 1'b0, 1'b0, 1'b0);
        rchk(RH, 8'h0F);
        wr(ST, 8'h84);
        i_line.send_char(8'h99, 1'b0, 1'b0, 1'b0);
        dma_rx_read <= 1'b1;
        @(posedge clk_sys);
        dma_rx_read <= 1'b0;
        rchk(ST, 8'h84);
    endtask
    task automatic t_multiproc();
        wr(MD, 8'h04);
        wr(CT, 8'h58);
        i_line.send_char(8'h11, 1'b0, 1'b0, 1'b1);
        rchk(ST, 8'h84);
        i_line.send_char(8'h22, 1'b1, 1'b0, 1'b0);
        rchk(ST, 8'hC6);
        rchk(CT, 8'h50);
        rchk(RH, 8'h22);
        wr(ST, 8'h84);
        wr(CT, 8'h00);
    endtask
    task automatic t_clock();
        logic [31:0] tab [12] = '{32'h0080_0000, 32'h0080_0102, 32'h0080_0200,
            32'h8080_0002, 32'h8080_0300, 32'h0081_0000, 32'h0081_0102, 32'h0081_0200,
            32'h8081_0006, 32'h8081_0207, 32'h8081_0102, 32'h8081_0302};
        for (int k = 0; k < 12; k++) begin
            wr(MD, tab[k][31:24]);
            wr(CD, tab[k][23:16]);
            wr(CT, tab[k][15:8]);
            settle(3);
            `CHK(sck_pin_oe, tab[k][1])
            if (tab[k][2]) `CHK(sck_pin_out, tab[k][0])
        end
        rchk(CD, 8'hF3);
        wr(CD, 8'h80);
        wr(CT, 8'h12);
        i_line.send_char(8'h5A, 1'b0, 1'b0, 1'b0);
        rchk(RH, 8'h5A);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_transmit();
        t_receive();
        t_multiproc();
        t_clock();
        final_report();
    end
endmodule

/* File: verilog/sccsf_serial_ctrl.sv */
// control, status and clock pin logic of one serial channel
`timescale 1ns/1ps
module sccsf_serial_ctrl (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic [2:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire sccsf_pkg::sccsf_rx_evt_t rx_evt,
    input  wire logic                    tx_load,
    input  wire logic                    tx_last_bit,
    input  wire logic                    dma_tx_write,
    input  wire logic [7:0]              dma_tx_data,
    input  wire logic                    dma_rx_read,
    input  wire logic                    bit_clk,
    input  wire logic                    rxd_pin,
    input  wire logic                    sck_pin_in,
    output logic                         sck_pin_out,
    output logic                         sck_pin_oe,
    output logic                         ext_clk_edge,
    output logic                         rx_start,
    output logic                         rx_halt,
    output logic                         tx_go,
    output logic                         tx_halt,
    output logic [7:0]                   tx_holding,
    output logic                         tx_mp_bit,
    output sccsf_pkg::sccsf_req_t        req
);
    // ======================================================
    // registers
    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [7:0] card_r;
    logic [7:0] rx_holding_r;
    logic       tx_data_empty_flag_r;
    logic       rx_data_full_flag_r;
    logic       overrun_flag_r;
    logic       fer_r;
    logic       per_r;
    logic       tx_end_flag_r;
    logic       mpb_r;
    logic       mpbt_r;
    logic [5:0] seen_r;
    logic       rx_busy_r;

    logic       card_mode_select;
    logic       sync_md;
    logic       mp_md;
    logic       te;
    logic       re;
    logic [1:0] cksel;
    logic       wr_stat;
    logic       rd_stat;
    logic       err_any;
    logic       rx_take;
    logic       rx_skip;
    logic [5:0] flag_vec;
    logic [5:0] clr_vec;

    assign card_mode_select    = card_r[sccsf_pkg::SCCSF_CM_CARD_MODE_SELECT];
    assign sync_md = mode_r[sccsf_pkg::SCCSF_MD_SYNC] & ~card_mode_select;
    assign mp_md   = mode_r[sccsf_pkg::SCCSF_MD_MP] & ~sync_md & ~card_mode_select;
    assign te      = ctrl_r[sccsf_pkg::SCCSF_CTL_TE];
    assign re      = ctrl_r[sccsf_pkg::SCCSF_CTL_RE];
    assign cksel   = {ctrl_r[sccsf_pkg::SCCSF_CTL_CKHI], ctrl_r[sccsf_pkg::SCCSF_CTL_CKLO]};
    assign wr_stat = reg_wr & (reg_addr == sccsf_pkg::SCCSF_OFS_STAT);
    assign rd_stat = reg_rd & (reg_addr == sccsf_pkg::SCCSF_OFS_STAT);
    assign err_any = overrun_flag_r | fer_r | per_r;

    // characters arriving while disabled or halted are ignored
    assign rx_take = rx_evt.done & re & ~err_any;
    // skip mode drops data characters
    assign rx_skip = mp_md & ctrl_r[sccsf_pkg::SCCSF_CTL_MULTIPROC_SKIP_ENABLE] & ~rx_evt.rx_multiproc_bit;

    // order: tx_data_empty_flag, rx_data_full_flag, overrun_flag, fer, per, tx_end_flag
    assign flag_vec = {tx_data_empty_flag_r, rx_data_full_flag_r, overrun_flag_r, fer_r, per_r, tx_end_flag_r};

    // a status write clears a flag only on a written zero after it was read as one
    always_comb begin
        clr_vec = 6'h00;
        if (wr_stat) begin
            clr_vec[5] = seen_r[5] & tx_data_empty_flag_r & ~reg_wdata[sccsf_pkg::SCCSF_ST_TX_DATA_EMPTY_FLAG];
            clr_vec[4] = seen_r[4] & rx_data_full_flag_r & ~reg_wdata[sccsf_pkg::SCCSF_ST_RX_DATA_FULL_FLAG];
            clr_vec[3] = seen_r[3] & overrun_flag_r & ~reg_wdata[sccsf_pkg::SCCSF_ST_OVERRUN_FLAG];
            clr_vec[2] = seen_r[2] & fer_r & ~reg_wdata[sccsf_pkg::SCCSF_ST_FER];
            clr_vec[1] = seen_r[1] & per_r & ~reg_wdata[sccsf_pkg::SCCSF_ST_PER];
        end
    end

    // ======================================================
    // read-as-one tracking
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= 6'h00;
        end else if (rd_stat) begin
            seen_r <= flag_vec;
        end else begin
            seen_r <= seen_r & flag_vec & ~clr_vec;
        end
    end

    // ======================================================
    // writable configuration
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= sccsf_pkg::SCCSF_RST_MODE;
            card_r <= sccsf_pkg::SCCSF_RST_CARD;
            mpbt_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == sccsf_pkg::SCCSF_OFS_MODE) begin
                mode_r <= reg_wdata;
            end
            if (reg_addr == sccsf_pkg::SCCSF_OFS_CARD) begin
                card_r <= reg_wdata | sccsf_pkg::SCCSF_CARD_RSV;
            end
            if (wr_stat) begin
                mpbt_r <= reg_wdata[sccsf_pkg::SCCSF_ST_MPBT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= sccsf_pkg::SCCSF_RST_CTRL;
        end else if (reg_wr && reg_addr == sccsf_pkg::SCCSF_OFS_CTRL) begin
            ctrl_r <= reg_wdata;
        end else if (rx_take && mp_md && rx_evt.rx_multiproc_bit) begin
            ctrl_r[sccsf_pkg::SCCSF_CTL_MULTIPROC_SKIP_ENABLE] <= 1'b0;
        end
    end

    // ======================================================
    // transmit holding register and empty / end flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_holding <= sccsf_pkg::SCCSF_RST_DATA;
        end else if (dma_tx_write) begin
            tx_holding <= dma_tx_data;
        end else if (reg_wr && reg_addr == sccsf_pkg::SCCSF_OFS_TXHOLD) begin
            tx_holding <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_empty_flag_r <= 1'b1;
        end else if (!te) begin
            tx_data_empty_flag_r <= 1'b1;
        end else if (tx_load) begin
            tx_data_empty_flag_r <= 1'b1;
        end else if (clr_vec[5] || dma_tx_write) begin
            tx_data_empty_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_end_flag_r <= 1'b1;
        end else if (!te || (tx_last_bit && tx_data_empty_flag_r)) begin
            tx_end_flag_r <= 1'b1;
        end else if (clr_vec[5] || dma_tx_write) begin
            tx_end_flag_r <= 1'b0;
        end
    end

    // ======================================================
    // receive flags and holding register; rx disable leaves them alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_full_flag_r       <= 1'b0;
            overrun_flag_r       <= 1'b0;
            fer_r        <= 1'b0;
            per_r        <= 1'b0;
            mpb_r        <= 1'b0;
            rx_holding_r <= sccsf_pkg::SCCSF_RST_DATA;
        end else begin
            if (rx_take && !rx_skip && rx_data_full_flag_r) begin
                overrun_flag_r <= 1'b1;
            end else if (clr_vec[3]) begin
                overrun_flag_r <= 1'b0;
            end
            if (rx_take && !rx_skip && !rx_data_full_flag_r && rx_evt.stop_err && !sync_md) begin
                fer_r <= 1'b1;
            end else if (clr_vec[2]) begin
                fer_r <= 1'b0;
            end
            if (rx_take && !rx_skip && !rx_data_full_flag_r && !rx_evt.stop_err && rx_evt.par_err
                && !mp_md) begin
                per_r <= 1'b1;
            end else if (clr_vec[1]) begin
                per_r <= 1'b0;
            end
            if (rx_take && !rx_skip && !rx_data_full_flag_r && !(rx_evt.stop_err && !sync_md)
                && !(rx_evt.par_err && !mp_md)) begin
                rx_data_full_flag_r <= 1'b1;
            end else if (clr_vec[4] || dma_rx_read) begin
                rx_data_full_flag_r <= 1'b0;
            end
            if (rx_take && !rx_skip && !rx_data_full_flag_r) begin
                rx_holding_r <= rx_evt.data;
            end
            if (rx_take && !rx_skip && mp_md) begin
                mpb_r <= rx_evt.rx_multiproc_bit;
            end
        end
    end

    // ======================================================
    // read port: data stands in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                sccsf_pkg::SCCSF_OFS_MODE:   reg_rdata <= mode_r;
                sccsf_pkg::SCCSF_OFS_CTRL:   reg_rdata <= ctrl_r;
                sccsf_pkg::SCCSF_OFS_STAT:   reg_rdata <= {flag_vec, mpb_r, mpbt_r};
                sccsf_pkg::SCCSF_OFS_CARD:   reg_rdata <= card_r;
                sccsf_pkg::SCCSF_OFS_TXHOLD: reg_rdata <= tx_holding;
                sccsf_pkg::SCCSF_OFS_RXHOLD: reg_rdata <= rx_holding_r;
                default:                     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ======================================================
    // pin synchronisers and edge detection
    logic [1:0] sck_sync_r;
    logic [1:0] rxd_sync_r;
    logic       sck_prev_r;
    logic       rxd_prev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // idle-high reset so no false clock edge follows reset
            sck_sync_r <= 2'b11;
            rxd_sync_r <= 2'b11;
            sck_prev_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            sck_sync_r <= {sck_sync_r[0], sck_pin_in};
            rxd_sync_r <= {rxd_sync_r[0], rxd_pin};
            sck_prev_r <= sck_sync_r[1];
            rxd_prev_r <= rxd_sync_r[1];
        end
    end

    // ======================================================
    // clock pin role
    sccsf_pkg::sccsf_ck_t ck_role;
    logic                 ck_fix_lvl;

    always_comb begin
        ck_role    = sccsf_pkg::SCCSF_CK_PORT;
        ck_fix_lvl = 1'b0;
        if (card_mode_select) begin
            if (mode_r[sccsf_pkg::SCCSF_MD_GM]) begin
                if (cksel[0]) begin
                    ck_role = sccsf_pkg::SCCSF_CK_OUT;
                end else begin
                    ck_role    = sccsf_pkg::SCCSF_CK_FIX;
                    ck_fix_lvl = cksel[1];
                end
            end else if (cksel == 2'b01) begin
                ck_role = sccsf_pkg::SCCSF_CK_OUT;
            end
        end else if (sync_md) begin
            ck_role = cksel[1] ? sccsf_pkg::SCCSF_CK_IN : sccsf_pkg::SCCSF_CK_OUT;
        end else if (cksel[1]) begin
            ck_role = sccsf_pkg::SCCSF_CK_IN;
        end else if (cksel[0]) begin
            ck_role = sccsf_pkg::SCCSF_CK_OUT;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_pin_out  <= 1'b0;
            sck_pin_oe   <= 1'b0;
            ext_clk_edge <= 1'b0;
        end else begin
            case (ck_role)
                sccsf_pkg::SCCSF_CK_OUT: begin
                    sck_pin_out <= bit_clk;
                    sck_pin_oe  <= 1'b1;
                end
                sccsf_pkg::SCCSF_CK_FIX: begin
                    sck_pin_out <= ck_fix_lvl;
                    sck_pin_oe  <= 1'b1;
                end
                default: begin
                    sck_pin_out <= 1'b0;
                    sck_pin_oe  <= 1'b0;
                end
            endcase
            ext_clk_edge <= (ck_role == sccsf_pkg::SCCSF_CK_IN) & sck_sync_r[1] & ~sck_prev_r;
        end
    end

    // ======================================================
    // transfer start and halt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_busy_r <= 1'b0;
        end else if (rx_evt.done || !re) begin
            rx_busy_r <= 1'b0;
        end else if (rx_start) begin
            rx_busy_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_start  <= 1'b0;
            rx_halt   <= 1'b0;
            tx_go     <= 1'b0;
            tx_halt   <= 1'b0;
            tx_mp_bit <= 1'b0;
        end else begin
            if (sync_md) begin
                rx_start <= re & ~err_any & ~rx_busy_r & ~rx_start
                            & (cksel[1] ? (sck_sync_r[1] ^ sck_prev_r) : 1'b1);
            end else begin
                rx_start <= re & ~err_any & ~rx_busy_r & ~rx_start
                            & ~rxd_sync_r[1] & rxd_prev_r;
            end
            rx_halt   <= err_any | ~re;
            tx_go     <= te & ~tx_data_empty_flag_r & ~(sync_md & err_any);
            tx_halt   <= ~te | (sync_md & err_any);
            tx_mp_bit <= mpbt_r;
        end
    end

    // ======================================================
    // interrupt requests
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req.tx_empty_request <= ctrl_r[sccsf_pkg::SCCSF_CTL_TIE] & tx_data_empty_flag_r;
            req.rx_full_request  <= ctrl_r[sccsf_pkg::SCCSF_CTL_RIE] & rx_data_full_flag_r;
            req.rx_error_request <= ctrl_r[sccsf_pkg::SCCSF_CTL_RIE] & err_any;
            req.tx_end_request   <= ctrl_r[sccsf_pkg::SCCSF_CTL_TX_END_IRQ_ENABLE] & tx_end_flag_r;
        end
    end
endmodule
